// ==== hw/dqtc_pkg.sv ====
package dqtc_pkg;

  // ---------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------
  localparam int DQ_W       = 36;
  localparam int ADDR_W     = 21;
  localparam int HALVES     = 2;
  localparam int OP_DEPTH   = 3;
  localparam int RD_LATENCY = 3;

  // ---------------------------------------------------------------
  // Operation and bus state encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DQTC_OP_RD,
    DQTC_OP_WR,
    DQTC_OP_IDLE_R,
    DQTC_OP_IDLE_W
  } dqtc_op_e;

  typedef enum logic [1:0] {
    DQTC_BUS_TERM,
    DQTC_BUS_LOW,
    DQTC_BUS_RD,
    DQTC_BUS_UNDEF
  } dqtc_bus_e;

  // Pad control for one cycle
  typedef struct packed {
    logic drive;
    logic odt;
    logic data;
  } dqtc_drv_s;

  localparam dqtc_drv_s DRV_RESET = '{drive: 1'b0, odt: 1'b1, data: 1'b0};

endpackage : dqtc_pkg

// ==== hw/dqtc_wr_half.sv ====
`timescale 1ns/1ns
`default_nettype none
module dqtc_wr_half #(
  parameter int HW = 18
) (
  // Master clock domain
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // Link side
  input  wire logic          wr_data_clk,
  input  wire logic [HW-1:0] dq_half,
  // Captured write beats
  output logic      [HW-1:0] beat1_o,
  output logic      [HW-1:0] beat2_o,
  output logic               vld_o
);

  // ---------------------------------------------------------------
  // Link domain capture
  // ---------------------------------------------------------------
  logic          lrst_s1_q;
  logic          lrst_s2_q;
  logic [HW-1:0] rise_q;
  logic [HW-1:0] pair1_q;
  logic [HW-1:0] pair2_q;
  logic          tog_q;

  always_ff @(posedge wr_data_clk) begin
    lrst_s1_q <= sys_rst;
    lrst_s2_q <= lrst_s1_q;
  end

  always_ff @(posedge wr_data_clk) begin
    rise_q <= dq_half; // RULE16
  end

  // Whole pair handed over at the falling edge, stable for a full period
  always_ff @(negedge wr_data_clk) begin
    if (lrst_s2_q) begin
      tog_q <= 1'b0;
    end else begin
      pair1_q <= rise_q;  // RULE16
      pair2_q <= dq_half; // RULE16
      tog_q   <= ~tog_q;
    end
  end

  // ---------------------------------------------------------------
  // Toggle crossing into the master clock domain
  // ---------------------------------------------------------------
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_s3_q;
  wire  take_w = tog_s2_q ^ tog_s3_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
      vld_o    <= 1'b0;
      beat1_o  <= '0;
      beat2_o  <= '0;
    end else begin
      tog_s1_q <= tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
      vld_o    <= take_w;
      if (take_w) begin
        beat1_o <= pair1_q;
        beat2_o <= pair2_q;
      end
    end
  end

endmodule : dqtc_wr_half
`default_nettype wire

// ==== hw/dqtc_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// RULE1: Launch and direction sampled each edge, decoded.
// RULE2: Bus state n+2, n+3 from n-1, n, n+1.
// RULE3: Cycle n+3: read data, Low or termination.
// RULE4: Cycle n+2: read data, Low, undefined or termination.
// RULE5: Controller never follows Read with write-side.
// RULE6: Write then read-side: termination off 2.5 cycles.
// RULE7: No idles before Read: one Low cycle first.
// RULE8: Controller inserts one to two idles before Read.
// RULE9: Two read-side idles before write-side; Low cycle.
// RULE10: Controller issues three to four idles after Read.
// RULE11: Three write-side idles before Write minimum.
// RULE12: Controller issues four to five idles before Write.
// RULE13: Controller termination only while receiving; else Low.
// RULE14: Termination on except read-side phase; else Low.
// RULE15: Address, launch, direction latched on master edge.
// RULE16: Write halves latched on both data clock edges.
// RULE17: Direction High: termination off, drive Low.
// RULE18: Direction Low: drivers off, termination on.
// RULE19: Read data three cycles later; write beats now.
// RULE20: Shift pipeline tracks previous, current, next operations.
// RULE21: Controller counts idles before direction change.
module dqtc_top #(
  parameter int DQ_W   = dqtc_pkg::DQ_W,
  parameter int ADDR_W = dqtc_pkg::ADDR_W
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // Command pins
  input  wire logic                   op_launch_n,
  input  wire logic                   dir_rd,
  input  wire logic [ADDR_W-1:0]      addr_in,
  // Data bus pins
  input  wire logic [dqtc_pkg::HALVES-1:0] wr_data_clk,
  input  wire logic [DQ_W-1:0]        dq_in,
  output logic      [DQ_W-1:0]        dq_q1_o,
  output logic      [DQ_W-1:0]        dq_q2_o,
  output logic                        dq_oe_n_o,
  output logic                        odt_en_o,
  // Status
  output dqtc_pkg::dqtc_bus_e         bus_st_o,
  output logic                        seq_err_o,
  // Array side
  output logic                        arr_rd_en_o,
  output logic                        arr_wr_en_o,
  output logic      [ADDR_W-1:0]      arr_addr_o,
  input  wire logic [2*DQ_W-1:0]      arr_rd_data_i,
  output logic      [DQ_W-1:0]        wr_beat1_o,
  output logic      [DQ_W-1:0]        wr_beat2_o,
  output logic [dqtc_pkg::HALVES-1:0] wr_half_vld_o
);

  localparam int HW = DQ_W / dqtc_pkg::HALVES;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic dqtc_pkg::dqtc_op_e op_decode(input logic launch_n, input logic rd);
    if (!launch_n) begin
      op_decode = rd ? dqtc_pkg::DQTC_OP_RD : dqtc_pkg::DQTC_OP_WR;
    end else begin
      op_decode = rd ? dqtc_pkg::DQTC_OP_IDLE_R : dqtc_pkg::DQTC_OP_IDLE_W;
    end
  endfunction : op_decode

  function automatic logic read_side(input dqtc_pkg::dqtc_op_e op);
    read_side = (op == dqtc_pkg::DQTC_OP_RD) || (op == dqtc_pkg::DQTC_OP_IDLE_R);
  endfunction : read_side

  // ---------------------------------------------------------------
  // Operation pipeline
  // ---------------------------------------------------------------
  // Pins sit on the master clock, so they are latched directly
  dqtc_pkg::dqtc_op_e op_q [dqtc_pkg::OP_DEPTH];

  wire dqtc_pkg::dqtc_op_e op_in_w = op_decode(op_launch_n, dir_rd); // RULE1
  wire in_rd_w    = (op_in_w == dqtc_pkg::DQTC_OP_RD);
  wire in_wr_w    = (op_in_w == dqtc_pkg::DQTC_OP_WR);
  wire in_rside_w = read_side(op_in_w);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      op_q[0] <= dqtc_pkg::DQTC_OP_IDLE_W;
    end else begin
      op_q[0] <= op_in_w; // RULE15 RULE20
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < dqtc_pkg::OP_DEPTH; gi++) begin : g_pipe
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          op_q[gi] <= dqtc_pkg::DQTC_OP_IDLE_W;
        end else begin
          op_q[gi] <= op_q[gi-1]; // RULE20
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Bus state selection
  // ---------------------------------------------------------------
  // State of cycle m depends on op(m-3) and op(m-2); both tables agree
  wire older_rd_w  = (op_q[2] == dqtc_pkg::DQTC_OP_RD);
  wire newer_rs_w  = read_side(op_q[1]);

  wire dqtc_pkg::dqtc_bus_e bus_d_w =
      (older_rd_w &&  newer_rs_w) ? dqtc_pkg::DQTC_BUS_RD :    // RULE2 RULE3 RULE4
      (older_rd_w && !newer_rs_w) ? dqtc_pkg::DQTC_BUS_UNDEF : // RULE4 RULE5
      newer_rs_w                  ? dqtc_pkg::DQTC_BUS_LOW :   // RULE3 RULE7 RULE17
                                    dqtc_pkg::DQTC_BUS_TERM;   // RULE18

  // Undefined slot is driven Low: never floats the bus toward mid-rail
  dqtc_pkg::dqtc_drv_s drv_d;
  assign drv_d.drive = (bus_d_w != dqtc_pkg::DQTC_BUS_TERM); // RULE14
  assign drv_d.odt   = (bus_d_w == dqtc_pkg::DQTC_BUS_TERM); // RULE14 RULE6
  assign drv_d.data  = (bus_d_w == dqtc_pkg::DQTC_BUS_RD);

  dqtc_pkg::dqtc_drv_s drv_q;
  logic [2*DQ_W-1:0]   rd_hold_q;
  logic [2*DQ_W-1:0]   rd_slot_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drv_q    <= dqtc_pkg::DRV_RESET;
      bus_st_o <= dqtc_pkg::DQTC_BUS_TERM;
      dq_q1_o  <= '0;
      dq_q2_o  <= '0;
    end else begin
      drv_q    <= drv_d;
      bus_st_o <= bus_d_w;
      dq_q1_o  <= drv_d.data ? rd_slot_q[DQ_W-1:0]      : '0; // RULE19
      dq_q2_o  <= drv_d.data ? rd_slot_q[2*DQ_W-1:DQ_W] : '0; // RULE19
    end
  end

  assign dq_oe_n_o = ~drv_q.drive;
  assign odt_en_o  = drv_q.odt;

  // ---------------------------------------------------------------
  // Array requests
  // ---------------------------------------------------------------
  // Array answers one cycle after the request; held until the bus slot
  // Two stages, so back-to-back reads keep their own data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arr_rd_en_o <= 1'b0;
      arr_wr_en_o <= 1'b0;
      arr_addr_o  <= '0;
      rd_hold_q   <= '0;
      rd_slot_q   <= '0;
      seq_err_o   <= 1'b0;
    end else begin
      arr_rd_en_o <= in_rd_w;
      arr_wr_en_o <= in_wr_w;
      if (in_rd_w || in_wr_w) begin
        arr_addr_o <= addr_in; // RULE15
      end
      if (arr_rd_en_o) begin
        rd_hold_q <= arr_rd_data_i;
      end
      rd_slot_q <= rd_hold_q; // RULE19
      seq_err_o <= (op_q[0] == dqtc_pkg::DQTC_OP_RD) && !in_rside_w; // RULE5
    end
  end

  // ---------------------------------------------------------------
  // Write data halves
  // ---------------------------------------------------------------
  generate
    for (gi = 0; gi < dqtc_pkg::HALVES; gi++) begin : g_half
      dqtc_wr_half #(
        .HW(HW)
      ) u_half (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .wr_data_clk(wr_data_clk[gi]),
        .dq_half    (dq_in[gi*HW +: HW]),
        .beat1_o    (wr_beat1_o[gi*HW +: HW]),
        .beat2_o    (wr_beat2_o[gi*HW +: HW]),
        .vld_o      (wr_half_vld_o[gi])
      ); // RULE16
    end
  endgenerate

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  wire a_wside_w = !in_rside_w;
  wire a_term_w  = (bus_st_o == dqtc_pkg::DQTC_BUS_TERM);
  wire a_low_w   = (bus_st_o == dqtc_pkg::DQTC_BUS_LOW);
  wire a_rd_w    = (bus_st_o == dqtc_pkg::DQTC_BUS_RD);

  sequence s_rd_to_wr;
    in_rd_w ##1 (in_rside_w && !in_rd_w) [*2] ##1 a_wside_w;
  endsequence

  AST_RD_DATA: assert property (in_rd_w ##1 in_rside_w |-> ##3 a_rd_w) // RULE3
    else $error("read data not on bus three cycles after read");
  AST_LOW_BEFORE_RD: assert property (!in_rd_w ##1 in_rd_w ##1 in_rside_w |-> ##2 a_low_w ##1 a_rd_w) // RULE7
    else $error("missing Low cycle before first read beat");
  AST_TERM: assert property (!in_rd_w ##1 a_wside_w |-> ##3 a_term_w) // RULE3
    else $error("bus not terminated after write-side op");
  AST_N2_LOW: assert property (!in_rd_w ##1 in_rside_w |-> ##3 a_low_w) // RULE4
    else $error("cycle n+2 not Low after non-read");
  AST_WR2RD_ODT: assert property (!in_rd_w ##1 in_wr_w ##1 in_rside_w |-> ##2 odt_en_o ##1 !odt_en_o) // RULE6
    else $error("termination not released after write");
  AST_RD2WR: assert property (s_rd_to_wr |-> ##1 a_rd_w ##1 a_low_w ##1 a_term_w) // RULE9
    else $error("read to write turnaround wrong");
  AST_NO_FIGHT: assert property (!(odt_en_o && !dq_oe_n_o)) // RULE14 RULE17 RULE18
    else $error("termination on while driving");
  AST_SEQ_ERR: assert property (in_rd_w ##1 a_wside_w |=> seq_err_o) // RULE5
    else $error("illegal read follow-up not flagged");
  AST_ADDR: assert property (in_rd_w |=> arr_rd_en_o && (arr_addr_o == $past(addr_in))) // RULE15
    else $error("address not latched with read");
  AST_RD_ZERO: assert property (!a_rd_w |-> (dq_q1_o == '0) && (dq_q2_o == '0)) // RULE14
    else $error("data lines not Low outside read data");

  COV_RD2WR: cover property (s_rd_to_wr);
  COV_WR2RD: cover property (in_wr_w ##1 in_rd_w);
  COV_BACK2BACK_RD: cover property (in_rd_w [*3]);
  COV_WR_DATA: cover property (wr_half_vld_o == 2'h3);

endmodule : dqtc_top
`default_nettype wire

// ==== testbench/dqtc_ctrl_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module dqtc_ctrl_model (
  // Command from the bench
  input  wire dqtc_pkg::dqtc_op_e cmd,
  input  wire logic [20:0]        cmd_addr,
  // Command pins
  output logic                    op_launch_n,
  output logic                    dir_rd,
  output logic [20:0]             addr_in,
  // Write data link
  output logic [1:0]              wr_data_clk,
  output logic [35:0]             dq_in,
  // Array stand-in
  input  wire logic [20:0]        arr_addr_o,
  output logic [71:0]             arr_rd_data_i
);
  // ----------------------------------------
  // Command encoding
  // ----------------------------------------
  // Only issues what the bench orders; bad turnarounds are deliberate
  assign op_launch_n = !(cmd == dqtc_pkg::DQTC_OP_RD || cmd == dqtc_pkg::DQTC_OP_WR);
  assign dir_rd      = cmd == dqtc_pkg::DQTC_OP_RD || cmd == dqtc_pkg::DQTC_OP_IDLE_R;
  assign addr_in     = cmd_addr;
  // Address-tagged data so a stale read is visible
  assign arr_rd_data_i = {36'(arr_addr_o) ^ 36'h5A5A5A5A5, 36'(arr_addr_o)};

  // ----------------------------------------
  // Write link
  // ----------------------------------------
  initial begin
    wr_data_clk = 2'h0;
    dq_in       = 36'h0;
  end

  // Link clock stands still between pairs
  task automatic link_pair(input logic [35:0] d1, input logic [35:0] d2);
    dq_in = d1;
    #40 wr_data_clk = 2'h3;
    #40 dq_in = d2;
    #40 wr_data_clk = 2'h0;
    #40 dq_in = 36'h0;
  endtask : link_pair
endmodule : dqtc_ctrl_model
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam dqtc_pkg::dqtc_op_e R  = dqtc_pkg::DQTC_OP_RD;
  localparam dqtc_pkg::dqtc_op_e W  = dqtc_pkg::DQTC_OP_WR;
  localparam dqtc_pkg::dqtc_op_e IR = dqtc_pkg::DQTC_OP_IDLE_R;
  localparam dqtc_pkg::dqtc_op_e IW = dqtc_pkg::DQTC_OP_IDLE_W;
  logic                clk, sys_rst, op_launch_n, dir_rd, dq_oe_n_o, odt_en_o;
  logic                seq_err_o, arr_rd_en_o, arr_wr_en_o;
  logic [20:0]         cmd_addr, addr_in, arr_addr_o;
  logic [1:0]          wr_data_clk, wr_half_vld_o;
  logic [35:0]         dq_in, dq_q1_o, dq_q2_o, wr_beat1_o, wr_beat2_o;
  logic [71:0]         arr_rd_data_i;
  dqtc_pkg::dqtc_op_e  cmd;
  dqtc_pkg::dqtc_bus_e bus_st_o;
  dqtc_pkg::dqtc_op_e  hist[int];
  int                  e, miscompares, samples_checked;

  dqtc_top DUT (.clk(clk), .sys_rst(sys_rst), .op_launch_n(op_launch_n), .dir_rd(dir_rd),
    .addr_in(addr_in), .wr_data_clk(wr_data_clk), .dq_in(dq_in), .dq_q1_o(dq_q1_o),
    .dq_q2_o(dq_q2_o), .dq_oe_n_o(dq_oe_n_o), .odt_en_o(odt_en_o), .bus_st_o(bus_st_o),
    .seq_err_o(seq_err_o), .arr_rd_en_o(arr_rd_en_o), .arr_wr_en_o(arr_wr_en_o),
    .arr_addr_o(arr_addr_o), .arr_rd_data_i(arr_rd_data_i), .wr_beat1_o(wr_beat1_o),
    .wr_beat2_o(wr_beat2_o), .wr_half_vld_o(wr_half_vld_o));
  dqtc_ctrl_model m (.cmd(cmd), .cmd_addr(cmd_addr), .op_launch_n(op_launch_n),
    .dir_rd(dir_rd), .addr_in(addr_in), .wr_data_clk(wr_data_clk), .dq_in(dq_in),
    .arr_addr_o(arr_addr_o), .arr_rd_data_i(arr_rd_data_i));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic chk_val(input logic [71:0] got, input logic [71:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bus(input dqtc_pkg::dqtc_bus_e got, input dqtc_pkg::dqtc_bus_e exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bus

  task automatic print_verdict();
    $display("checked=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  function automatic dqtc_pkg::dqtc_op_e op_at(input int k);
    return hist.exists(k) ? hist[k] : IW;
  endfunction : op_at

  function automatic logic rside(input dqtc_pkg::dqtc_op_e o);
    return o == R || o == IR;
  endfunction : rside

  // ----------------------------------------
  // Op runner: judges every slot
  // ----------------------------------------
  task automatic run_ops(input dqtc_pkg::dqtc_op_e s[$]);
    dqtc_pkg::dqtc_op_e  p3, p2, p1;
    dqtc_pkg::dqtc_bus_e x;
    foreach (s[i]) begin
      cmd = s[i];
      cmd_addr = 21'(e);
      hist[e] = s[i];
      @(posedge clk);
      #2;
      p3 = op_at(e - 3);
      p2 = op_at(e - 2);
      p1 = op_at(e - 1);
      x = (p3 == R) ? (rside(p2) ? dqtc_pkg::DQTC_BUS_RD : dqtc_pkg::DQTC_BUS_UNDEF)
                    : (rside(p2) ? dqtc_pkg::DQTC_BUS_LOW : dqtc_pkg::DQTC_BUS_TERM);
      chk_bus(bus_st_o, x);
      chk_val({odt_en_o, dq_oe_n_o}, {2{x == dqtc_pkg::DQTC_BUS_TERM}});
      chk_val({dq_q2_o, dq_q1_o}, (x == dqtc_pkg::DQTC_BUS_RD) ?
              {36'(e - 3) ^ 36'h5A5A5A5A5, 36'(e - 3)} : 72'h0);
      chk_val(seq_err_o, p1 == R && !rside(s[i]));
      chk_val({arr_rd_en_o, arr_wr_en_o}, {s[i] == R, s[i] == W});
      if (s[i] == R || s[i] == W) begin
        chk_val(arr_addr_o, 21'(e));
      end
      e++;
    end
  endtask : run_ops

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_tight_turns();
    run_ops('{IW, IW, IW, W, R, R, IR, IR, IW, IW, IW, W, IW});
  endtask : sc_tight_turns

  task automatic sc_typical_turns();
    run_ops('{IR, IR, R, R, R, IR, IR, IR, IR, IW, IW, IW, IW, W, IW});
  endtask : sc_typical_turns

  task automatic sc_bad_turn();
    run_ops('{IR, R, IW, R, W, IR, IR, IW, IW, IW});
  endtask : sc_bad_turn

  task automatic sc_write_capture();
    int n;
    fork
      run_ops('{W, IW, IW, IW, IW, IW, IW, IW, IW, IW, IW, IW, IW, IW});
      begin
        #7 m.link_pair(36'h123456789, 36'hFEDCBA987);
        for (n = 0; n < 20 && wr_half_vld_o !== 2'h3; n++) begin
          @(posedge clk);
          #3;
        end
        if (n == 20) begin
          miscompares++;
          print_verdict();
        end else begin
          chk_val({wr_beat2_o, wr_beat1_o}, {36'hFEDCBA987, 36'h123456789});
        end
      end
    join
  endtask : sc_write_capture

  initial begin
    sys_rst = 1'b1;
    cmd = IW;
    cmd_addr = 21'h0;
    e = 0;
    miscompares = 0;
    samples_checked = 0;
    // Link reset needs link edges, so hold past them
    fork
      repeat (5) @(posedge clk);
      repeat (3) m.link_pair(36'h0, 36'h0);
    join
    @(posedge clk);
    #2;
    chk_bus(bus_st_o, dqtc_pkg::DQTC_BUS_TERM);
    chk_val({odt_en_o, dq_oe_n_o, seq_err_o}, 3'h6);
    sys_rst = 1'b0;
    // Link reset leaves only on link edges, so flush two idle pairs
    repeat (2) m.link_pair(36'h0, 36'h0);
    sc_tight_turns();
    sc_typical_turns();
    sc_bad_turn();
    sc_write_capture();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
